/* logic/sltc_pkg.sv */
// shared constants and types for the transmit control block
package sltc_pkg;
    // ------------------------------------------------------------
    // register addresses on the four address signals
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SILO = 4'h8;
    localparam logic [3:0] ADDR_CTL = 4'h9;
    // ------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------
    localparam int BIT_SOM = 0;
    localparam int BIT_EOM = 1;
    localparam int BIT_RDY = 4;
    localparam int BIT_SW = 5;
    localparam int BIT_ACT = 6;
    localparam int BIT_CLR = 7;
    // ------------------------------------------------------------
    // widths, line constants
    // ------------------------------------------------------------
    localparam int CTL_W = 4;
    localparam int CHAR_W = 8;
    localparam int ENTRY_W = CTL_W + CHAR_W;
    localparam int FIFO_DEPTH = 8;
    localparam int BIT_DIV = 8;
    localparam logic [3:0] CTL_RESET = 4'h0;
    localparam logic [7:0] FLAG_CHAR = 8'h7e;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [3:0] CHAR_BITS = 4'h8;
    // transmit sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_CRC1 = 3'b011,
        ST_CRC2 = 3'b010,
        ST_TERM = 3'b110
    } sltc_state_t;
endpackage

/* logic/sltc_chan_if.sv */
// channel between sequencer, silo and serializer
`timescale 1ns/1ps
interface sltc_chan_if;
    import sltc_pkg::*;
    logic pushValid;
    logic pushReady;
    logic [ENTRY_W-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [ENTRY_W-1:0] popData;
    logic load;
    logic rdy;
    logic busy;
    logic stuffEn;
    logic crcAcc;
    logic crcClr;
    logic [7:0] txByte;
    logic [15:0] crcVal;
    modport ctl(output pushValid, pushData, popReady, load, stuffEn, crcAcc, crcClr, txByte,
                input pushReady, popValid, popData, rdy, busy, crcVal);
    modport fifo(input pushValid, pushData, popReady, output pushReady, popValid, popData);
    modport ser(input load, stuffEn, crcAcc, crcClr, txByte, output rdy, busy, crcVal);
endinterface

/* logic/sltc_fifo.sv */
// outbound character silo with registered read stage
`timescale 1ns/1ps
module sltc_fifo #(
    parameter int WIDTH = sltc_pkg::ENTRY_W,
    parameter int DEPTH = sltc_pkg::FIFO_DEPTH
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    // channel
    sltc_chan_if.fifo ch
);
    import sltc_pkg::*;
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH != ENTRY_W) begin : g_bad
        $error("sltc_fifo: depth must be a power of two and width must match the entry");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0] count_reg, count_next;
    logic outValid_reg, outValid_next;
    logic [WIDTH-1:0] outData_reg;
    logic doWr, doRd;
    // full stops the writer; the output stage refills whenever it drains
    always_comb begin
        doWr = ch.pushValid && (count_reg != (AW+1)'(DEPTH));
        doRd = (count_reg != '0) && (!outValid_reg || ch.popReady);
        wrPtr_next = doWr ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = doRd ? rdPtr_reg + 1'b1 : rdPtr_reg;
        count_next = count_reg + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
        outValid_next = doRd || (outValid_reg && !ch.popReady);
        if (clr) begin
            wrPtr_next = '0;
            rdPtr_next = '0;
            count_next = '0;
            outValid_next = 1'b0;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            outValid_reg <= 1'b0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            outValid_reg <= outValid_next;
        end
    end
    // storage and registered read data carry no reset
    always_ff @(posedge core_clk) begin
        if (doWr && !clr) begin
            mem[wrPtr_reg] <= ch.pushData;
        end
        if (doRd) begin
            outData_reg <= mem[rdPtr_reg];
        end
    end
    assign ch.pushReady = (count_reg != (AW+1)'(DEPTH));
    assign ch.popValid = outValid_reg;
    assign ch.popData = outData_reg;
endmodule

/* logic/sltc_ser.sv */
// bit serializer with zero insertion and crc accumulation
`timescale 1ns/1ps
module sltc_ser #(
    parameter int DIV = sltc_pkg::BIT_DIV
) (
    // clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clr,
    // channel and line
    sltc_chan_if.ser ch,
    output logic txLine
);
    import sltc_pkg::*;
    if (DIV < 2 || DIV > 65535) begin : g_bad
        $error("sltc_ser: divider out of range");
    end
    logic [15:0] div_reg, div_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [2:0] ones_reg, ones_next;
    logic busy_reg, busy_next, stuff_reg, stuff_next, acc_reg, acc_next, line_reg, line_next;
    logic [15:0] crc_reg, crc_next;
    logic tick, bitOut;
    // one bit time per divider wrap
    always_comb begin
        tick = (div_reg == '0);
        div_next = tick ? 16'(DIV - 1) : div_reg - 16'h1;
        {shift_next, bitCnt_next, ones_next} = {shift_reg, bitCnt_reg, ones_reg};
        {busy_next, stuff_next, acc_next, line_next} = {busy_reg, stuff_reg, acc_reg, line_reg};
        crc_next = ch.crcClr ? CRC_INIT : crc_reg;
        bitOut = shift_reg[0];
        if (ch.load && !busy_reg) begin
            shift_next = ch.txByte;
            bitCnt_next = CHAR_BITS;
            busy_next = 1'b1;
            stuff_next = ch.stuffEn;
            acc_next = ch.crcAcc;
        end else if (busy_reg && tick) begin
            if (stuff_reg && ones_reg == STUFF_RUN) begin
                line_next = 1'b0;
                ones_next = '0;
            end else if (bitCnt_reg != '0) begin
                line_next = bitOut;
                shift_next = {1'b0, shift_reg[7:1]};
                bitCnt_next = bitCnt_reg - 4'h1;
                ones_next = (bitOut && stuff_reg) ? ones_reg + 3'h1 : 3'h0;
                if (acc_reg) begin
                    crc_next = {1'b0, crc_reg[15:1]} ^ ((crc_reg[0] ^ bitOut) ? CRC_POLY : 16'h0);
                end
            end
            // a pending zero is owed to this character even after its last bit
            busy_next = !(bitCnt_next == '0 && !(stuff_reg && ones_next == STUFF_RUN));
        end else if (!busy_reg && tick) begin
            line_next = 1'b1;
        end
        if (clr) begin
            busy_next = 1'b0;
            ones_next = '0;
            line_next = 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            shift_reg <= '0;
            bitCnt_reg <= '0;
            ones_reg <= '0;
            {busy_reg, stuff_reg, acc_reg} <= 3'h0;
            line_reg <= 1'b1;
            crc_reg <= CRC_INIT;
        end else begin
            div_reg <= div_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            ones_reg <= ones_next;
            {busy_reg, stuff_reg, acc_reg} <= {busy_next, stuff_next, acc_next};
            line_reg <= line_next;
            crc_reg <= crc_next;
        end
    end
    assign ch.rdy = !busy_reg;
    assign ch.busy = busy_reg;
    assign ch.crcVal = crc_reg;
    assign txLine = line_reg;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_stuff_run;
        @(posedge core_clk) disable iff (rst) stuff_reg |-> ones_reg <= STUFF_RUN;
    endproperty
    a_stuff_run: assert property (p_stuff_run) else $error("run of ones too long");
    property p_stuff_zero;
        @(posedge core_clk) disable iff (rst)
            busy_reg && tick && stuff_reg && ones_reg == STUFF_RUN && !clr |=> !txLine;
    endproperty
    a_stuff_zero: assert property (p_stuff_zero) else $error("stuffed zero missing");
endmodule

/* logic/sltc_tx_control.sv */
// transmit control of the synchronous line unit
`timescale 1ns/1ps
module sltc_tx_control #(
    parameter int BIT_DIV = sltc_pkg::BIT_DIV,
    parameter int FIFO_DEPTH = sltc_pkg::FIFO_DEPTH
) (
    // clock and initialization
    input wire logic core_clk,
    input wire logic rst,
    // outbound bus from the processor
    input wire logic obusWrite,
    input wire logic [3:0] obusAddr,
    input wire logic [sltc_pkg::CHAR_W-1:0] obusData,
    // inbound read path to the processor
    input wire logic [3:0] ibusAddr,
    output logic [sltc_pkg::CHAR_W-1:0] ibusData,
    // static configuration and board switch
    input wire logic charSyncMode,
    input wire logic crcEnable,
    input wire logic boardSwitch,
    // serial line
    output logic txLine,
    output logic txActive
);
    import sltc_pkg::*;

    sltc_chan_if ch();

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic ctlWrite, siloWrite, txClear;
    logic [CTL_W-1:0] ctl_reg, ctl_next;

    // one write per cycle, so the control write and the silo load never collide
    always_comb begin
        ctlWrite = obusWrite && (obusAddr == ADDR_CTL);
        siloWrite = obusWrite && (obusAddr == ADDR_SILO);
        txClear = ctlWrite && obusData[BIT_CLR];
    end

    // control bits wait here until the next character takes them
    always_comb begin
        ctl_next = ctl_reg;
        if (ctlWrite) begin
            ctl_next = txClear ? CTL_RESET : obusData[CTL_W-1:0];
        end
        if (siloWrite && ch.pushReady) begin
            ctl_next = CTL_RESET;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // a write while full is dropped; software is expected to poll ready
    assign ch.pushValid = siloWrite;
    assign ch.pushData = {ctl_reg, obusData};

    // ------------------------------------------------------------
    // board switch synchroniser
    // ------------------------------------------------------------
    logic sw1_reg, sw2_reg, sw3_reg, swStable_reg, swStable_next;

    // the switch only counts once the last two stages agree
    always_comb begin
        swStable_next = (sw2_reg == sw3_reg) ? sw3_reg : swStable_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {sw1_reg, sw2_reg, sw3_reg, swStable_reg} <= 4'h0;
        end else begin
            sw1_reg <= boardSwitch;
            sw2_reg <= sw1_reg;
            sw3_reg <= sw2_reg;
            swStable_reg <= swStable_next;
        end
    end

    // ------------------------------------------------------------
    // silo and serializer
    // ------------------------------------------------------------
    sltc_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) i_sltc_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .clr(txClear),
        .ch(ch.fifo)
    );

    sltc_ser #(
        .DIV(BIT_DIV)
    ) i_sltc_ser (
        .core_clk(core_clk),
        .rst(rst),
        .clr(txClear),
        .ch(ch.ser),
        .txLine(txLine)
    );

    // ------------------------------------------------------------
    // transmit sequencer
    // ------------------------------------------------------------
    sltc_state_t state_reg, state_next;
    logic [CHAR_W-1:0] fill_reg, fill_next;
    logic pre_reg, pre_next, lock_reg, lock_next;
    logic entSom, entEom, crcOn;
    logic [CHAR_W-1:0] entChar;

    always_comb begin
        entChar = ch.popData[CHAR_W-1:0];
        entSom = ch.popData[CHAR_W+BIT_SOM];
        entEom = ch.popData[CHAR_W+BIT_EOM];
        crcOn = crcEnable || lock_reg;
    end

    // decisions other than a clear are taken only between characters, when the serializer is free
    always_comb begin
        state_next = state_reg;
        fill_next = fill_reg;
        pre_next = pre_reg;
        lock_next = lock_reg;
        ch.popReady = 1'b0;
        ch.load = 1'b0;
        ch.txByte = fill_reg;
        ch.stuffEn = 1'b0;
        ch.crcAcc = 1'b0;
        ch.crcClr = 1'b0;
        if (txClear) begin
            state_next = ST_IDLE;
            pre_next = 1'b0;
            lock_next = 1'b0;
        end else if (ch.rdy) begin
            unique case (state_reg)
                ST_IDLE, ST_RUN: begin
                    if (ch.popValid) begin
                        ch.popReady = 1'b1;
                        ch.load = 1'b1;
                        if (entSom) begin
                            pre_next = 1'b1;
                            ch.crcClr = 1'b1;
                            state_next = ST_RUN;
                            if (charSyncMode) begin
                                fill_next = entChar;
                                ch.txByte = entChar;
                                lock_next = 1'b1;
                            end else begin
                                fill_next = FLAG_CHAR;
                                ch.txByte = FLAG_CHAR;
                            end
                        end else if (entEom && !charSyncMode) begin
                            ch.load = 1'b0;
                            pre_next = 1'b0;
                            state_next = ST_CRC1;
                        end else begin
                            pre_next = 1'b0;
                            ch.txByte = entChar;
                            ch.stuffEn = !charSyncMode;
                            ch.crcAcc = crcOn;
                            state_next = entEom ? ST_CRC1 : ST_RUN;
                        end
                    end else if (state_reg == ST_RUN) begin
                        ch.load = 1'b1;
                    end
                end
                ST_CRC1: begin
                    ch.load = 1'b1;
                    ch.txByte = ch.crcVal[7:0];
                    ch.stuffEn = !charSyncMode;
                    state_next = ST_CRC2;
                end
                ST_CRC2: begin
                    ch.load = 1'b1;
                    ch.txByte = ch.crcVal[15:8];
                    ch.stuffEn = !charSyncMode;
                    if (charSyncMode) begin
                        state_next = (ch.popValid && entSom) ? ST_RUN : ST_IDLE;
                    end else begin
                        state_next = ST_TERM;
                    end
                end
                ST_TERM: begin
                    ch.load = 1'b1;
                    ch.txByte = FLAG_CHAR;
                    fill_next = FLAG_CHAR;
                    if (ch.popValid && entEom) begin
                        ch.popReady = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            fill_reg <= FLAG_CHAR;
            pre_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fill_reg <= fill_next;
            pre_reg <= pre_next;
            lock_reg <= lock_next;
        end
    end

    // ------------------------------------------------------------
    // status and read-back
    // ------------------------------------------------------------
    logic act_reg, act_next;
    logic [CHAR_W-1:0] rd_reg, rd_next;

    // write-only bits read back as zero
    always_comb begin
        act_next = !txClear && (state_next != ST_IDLE || ch.busy || ch.load);
        rd_next = '0;
        if (ibusAddr == ADDR_CTL) begin
            rd_next[BIT_RDY] = ch.pushReady;
            rd_next[BIT_SW] = swStable_reg;
            rd_next[BIT_ACT] = act_reg;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            act_reg <= 1'b0;
            rd_reg <= '0;
        end else begin
            act_reg <= act_next;
            rd_reg <= rd_next;
        end
    end

    assign ibusData = rd_reg;
    assign txActive = act_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_ctlSet;
        ctlWrite && !txClear;
    endsequence
    sequence s_siloLoad;
        siloWrite && ch.pushReady;
    endsequence

    property p_capture;
        s_ctlSet ##1 s_siloLoad |-> ch.pushData[ENTRY_W-1:CHAR_W] == $past(obusData[CTL_W-1:0]);
    endproperty
    a_capture: assert property (p_capture) else $error("control bits not carried");

    property p_load_clears;
        siloWrite && ch.pushReady |=> ctl_reg == CTL_RESET;
    endproperty
    a_load_clears: assert property (p_load_clears) else $error("control bits kept");

    property p_lock_holds;
        lock_reg && !txClear |=> lock_reg;
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("crc lock dropped");

    property p_sync_nocrc;
        ch.load && charSyncMode && state_reg == ST_RUN && !ch.popValid |-> !ch.crcAcc;
    endproperty
    a_sync_nocrc: assert property (p_sync_nocrc) else $error("sync fill in crc");

    property p_flag_fill;
        ch.load && pre_reg && !charSyncMode && !ch.popValid && state_reg == ST_RUN
            |-> ch.txByte == FLAG_CHAR && !ch.stuffEn;
    endproperty
    a_flag_fill: assert property (p_flag_fill) else $error("flag fill wrong");

    property p_ready_read;
        ibusAddr == ADDR_CTL |=> ibusData[BIT_RDY] == $past(ch.pushReady);
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("ready bit wrong");

    property p_clear;
        txClear |=> !txActive && state_reg == ST_IDLE ##1 !ch.popValid;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");

    property p_shutdown;
        state_reg == ST_CRC2 && ch.rdy && charSyncMode && !txClear && !(ch.popValid && entSom)
            |=> state_reg == ST_IDLE;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown after crc");

    property p_eom_drop;
        state_reg == ST_RUN && ch.rdy && ch.popValid && entEom && !entSom && !charSyncMode && !txClear
            |-> !ch.load ##1 state_reg == ST_CRC1;
    endproperty
    a_eom_drop: assert property (p_eom_drop) else $error("end character sent");
endmodule

/* verification/sltc_line_rx.sv */
// serial line receiver model measuring runs of ones on the line
`timescale 1ns/1ps
module sltc_line_rx #(
    parameter int DIV = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // line and counters
    input wire logic txLine,
    input wire logic clrCounts,
    output int flagCount,
    output int longCount
);
    int run;
    // ------------------------------------------------------------
    // run length of ones, one sample per cycle
    // ------------------------------------------------------------
    // a flag is six ones between zeros; longer runs mean missing zero insertion or idle
    always @(posedge core_clk or posedge rst) begin
        if (rst || clrCounts) begin
            run <= 0;
            flagCount <= 0;
            longCount <= 0;
        end else if (txLine === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run == 6 * DIV) flagCount <= flagCount + 1;
            else if (run > 6 * DIV) longCount <= longCount + 1;
            run <= 0;
        end
    end
endmodule

/* verification/sync_line_tx_control_test.sv */
// self-checking testbench of the transmit control block
`timescale 1ns/1ps
module sync_line_tx_control_test;
    import sltc_pkg::*;
    logic core_clk = 0, rst = 1, obusWrite = 0, charSyncMode = 0, crcEnable = 1, boardSwitch = 0;
    logic [3:0] obusAddr = 4'h0, ibusAddr = 4'h0;
    logic [7:0] obusData = 8'h00;
    logic [7:0] ibusData;
    logic txLine, txActive, clrCounts = 0;
    int flagCount, longCount, failures = 0, total_checks = 0;
    // ------------------------------------------------------------
    // clock, design and line model
    // ------------------------------------------------------------
    always #2 core_clk = ~core_clk;
    sltc_tx_control #(.BIT_DIV(2), .FIFO_DEPTH(8)) i_sltc_tx_control (.core_clk(core_clk), .rst(rst),
        .obusWrite(obusWrite), .obusAddr(obusAddr), .obusData(obusData), .ibusAddr(ibusAddr),
        .ibusData(ibusData), .charSyncMode(charSyncMode), .crcEnable(crcEnable),
        .boardSwitch(boardSwitch), .txLine(txLine), .txActive(txActive));
    sltc_line_rx #(.DIV(2)) i_sltc_line_rx (.core_clk(core_clk), .rst(rst), .txLine(txLine),
        .clrCounts(clrCounts), .flagCount(flagCount), .longCount(longCount));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one write per two cycles so the strobe is never set twice in a time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        obusWrite = 1;
        obusAddr = a;
        obusData = d;
        step(1);
        obusWrite = 0;
        step(1);
    endtask
    // control bits then their character on consecutive edges, strobe held high in between
    task automatic wr_pair(input logic [7:0] c, input logic [7:0] d);
        obusWrite = 1;
        obusAddr = ADDR_CTL;
        obusData = c;
        step(1);
        obusAddr = ADDR_SILO;
        obusData = d;
        step(1);
        obusWrite = 0;
        step(1);
    endtask
    task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
        ibusAddr = a;
        step(1);
        chk(name, exp, ibusData);
    endtask
    task automatic wait_act(input logic exp, input int bound);
        int n;
        n = 0;
        while (txActive !== exp && n < bound) begin
            step(1);
            n++;
        end
        chk("txActive", {7'h0, exp}, {7'h0, txActive});
    endtask
    task automatic counts_clear();
        clrCounts = 1;
        step(1);
        clrCounts = 0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_reset_and_switch();
        rd("ctl after reset", ADDR_CTL, 8'h10);
        rd("silo read", ADDR_SILO, 8'h00);
        rd("unmapped read", 4'h3, 8'h00);
        boardSwitch = 1;
        step(6);
        rd("switch bit", ADDR_CTL, 8'h30);
        boardSwitch = 0;
        step(6);
    endtask
    task automatic s_bit_flags_and_fill();
        wr(ADDR_CTL, 8'h0d);
        wr(ADDR_SILO, 8'h00);
        wait_act(1'b1, 100);
        rd("start bit cleared", ADDR_CTL, 8'h50);
        step(20);
        counts_clear();
        step(80);
        chk("flags sent", 8'h1, {7'h0, flagCount >= 3});
        // a lone end entry holds the sequencer in crc and flag, so no pop races the fill below
        wr(ADDR_CTL, 8'h02);
        wr(ADDR_SILO, 8'h00);
        for (int i = 0; i < 12; i++) wr(ADDR_SILO, 8'hff);
        step(1);
        rd("silo full", ADDR_CTL, 8'h40);
        step(400);
        chk("zero insertion", 8'h0, longCount[7:0]);
        rd("silo room", ADDR_CTL, 8'h50);
        wr(ADDR_CTL, 8'h02);
        wr(ADDR_SILO, 8'h00);
        wr(ADDR_CTL, 8'h02);
        wr(ADDR_SILO, 8'h00);
        wait_act(1'b0, 400);
    endtask
    task automatic s_clear();
        wr(ADDR_CTL, 8'h01);
        wr(ADDR_SILO, 8'h00);
        wait_act(1'b1, 100);
        wr(ADDR_CTL, 8'h80);
        chk("active after clear", 8'h0, {7'h0, txActive});
        rd("ctl after clear", ADDR_CTL, 8'h10);
    endtask
    task automatic s_char_sync();
        charSyncMode = 1;
        wr(ADDR_CTL, 8'h01);
        wr(ADDR_SILO, 8'h96);
        wait_act(1'b1, 100);
        step(20);
        counts_clear();
        step(100);
        chk("no flags in sync", 8'h0, flagCount[7:0]);
        wr(ADDR_SILO, 8'h41);
        wr_pair(8'h02, 8'h42);
        wait_act(1'b0, 400);
    endtask
    // ------------------------------------------------------------
    // closing, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // the whole run needs about a thousand cycles of the 20000 this limit allows, so it only fires on a hang
    initial begin
        #80000;
        failures++;
        stop_test();
    end
    initial begin
        step(3);
        rst = 0;
        s_reset_and_switch();
        s_bit_flags_and_fill();
        s_clear();
        s_char_sync();
        stop_test();
    end
endmodule
